// ==== hw/sensor_slot_sched.sv ====
`timescale 1ns/100ps

// Summary of operation
// RULE1: send status codes while self-test runs
// RULE2: rerun failed self-test up to limit
// RULE3: stop repeating after one pass
// RULE4: phase length: test time plus two periods
// RULE5: close phase with exactly two final messages
// RULE6: free_run_sel ten-bit busy count up to 2107
// RULE7: sync eight-bit busy count up to 906
// RULE8: free_run_sel when normal, free-run, slot A zero
// RULE9: free_run_sel sends fixed-rate, ignores sync pulses
// RULE10: programming entry in phase one unless locked
// RULE11: simultaneous sampling: normal mode, latency clear
// RULE12: latch at sync edge, send at A
// RULE13: synchronous sampling: normal mode, latency set
// RULE14: latch and send together at slot A
// RULE15: double rate ignores the latency bit
// RULE16: double rate sends at A and B
// RULE17: init frames duplicated in both slots
// RULE18: overlapping slot B frame is suppressed
// RULE19: failed compare reruns the three test phases
// RULE20: passed test enters normal transmission
// RULE21: slot instants from one sync-based counter
// RULE22: busy per event, then two finals
// RULE23: master keeps constant sync period
module sensor_slot_sched #(
	parameter int unsigned   FREE_RUN_CYC = sched_pkg::FREE_RUN_CYC,
	parameter logic [9:0]    BUSY_CODE    = 10'h3A5,
	parameter logic [9:0]    READY_CODE   = 10'h35A,
	parameter logic [9:0]    DEFECT_CODE  = 10'h2C3
) (
	input  wire logic                 clk,
	input  wire logic                 arst_n,
	input  wire logic                 clk_en,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output logic [31:0]               prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic                 sync_rise,
	input  wire logic [9:0]           sample_in,
	input  wire logic                 selftest_done,
	input  wire logic                 selftest_pass,
	input  wire logic                 init1_active,
	input  wire logic                 prog_entry_cmd,
	output logic                      selftest_start,
	output logic                      tx_start,
	output sched_pkg::tx_frame_t      tx_frame,
	output logic                      prog_mode
);

	// ==================================================
	// parameter checks
	if (FREE_RUN_CYC < 2 || FREE_RUN_CYC > 32'h00FF_FFFF)
	begin : g_bad_period
		$error("free-run period out of range");
	end
	// RULE7: counter covers both maxima
	if (sched_pkg::BUSY_MAX_ASYNC10 >= (1 << sched_pkg::BUSY_CNT_W)
		|| sched_pkg::BUSY_MAX_SYNC8 >= (1 << sched_pkg::BUSY_CNT_W))
	begin : g_bad_cnt
		$error("busy counter too narrow");
	end

	// ==================================================
	// declarations
	sched_pkg::cfg_t        cfg_reg;
	logic [9:0]             slot_a_reg;
	logic [9:0]             slot_b_reg;
	sched_pkg::seq_state_t  state_reg;
	logic [2:0]             rerun_reg;
	logic                   st_done_reg;
	logic                   st_pass_reg;
	logic [1:0]             final_cnt_reg;
	logic [sched_pkg::BUSY_CNT_W-1:0] busy_cnt_reg;
	logic [4:0]             sub_reg;
	logic [9:0]             cnt_reg;
	logic                   armed_reg;
	logic [23:0]            free_cnt_reg;
	logic [9:0]             hold_reg;
	logic                   go_wr;
	logic                   free_run_sel_sel;
	logic                   simul_sel;
	logic                   dsr_sel;
	logic                   conflict;
	logic [1:0]             slot_hit;
	logic                   evt_a;
	logic                   evt_b;
	logic [10:0]            a_end;
	logic [10:0]            b_end;
	logic                   fin_open;
	logic                   send_a;

	function automatic logic is_free_run_sel(input sched_pkg::cfg_t c, input logic [9:0] a);
		return c.mode == sched_pkg::MODE_NORMAL && c.free_run && a == 10'h000;
	endfunction : is_free_run_sel

	// ==================================================
	// mode decode
	// RULE8: free_run_sel select
	assign free_run_sel_sel = is_free_run_sel(cfg_reg, slot_a_reg);
	// RULE13: latency set means synchronous
	// RULE11: simultaneous select
	assign simul_sel = !free_run_sel_sel && cfg_reg.mode == sched_pkg::MODE_NORMAL
		&& cfg_reg.latency == sched_pkg::LAT_SIMUL;
	// RULE15: double rate from mode only
	assign dsr_sel = cfg_reg.mode == sched_pkg::MODE_DSR;
	assign go_wr = psel && penable && pready && pwrite && clk_en
		&& paddr == sched_pkg::ADDR_CTRL && pwdata[sched_pkg::CTRL_GO_BIT];

	// RULE18: frames overlap when each starts before the other ends
	assign a_end = {1'b0, slot_a_reg} + {1'b0, cfg_reg.flen};
	assign b_end = {1'b0, slot_b_reg} + {1'b0, cfg_reg.flen};
	assign conflict = ({1'b0, slot_b_reg} < a_end) && ({1'b0, slot_a_reg} < b_end);

	// ==================================================
	// slot time base
	// RULE21: both slot instants compare against one counter
	for (genvar s = 0; s < 2; s++)
	begin : g_slot
		assign slot_hit[s] = armed_reg && sub_reg == 5'h00
			&& cnt_reg == (s == 0 ? slot_a_reg : slot_b_reg);
	end
	// RULE9: free-run events replace sync-driven ones
	assign evt_a = free_run_sel_sel ? (free_cnt_reg == 24'h000000) : slot_hit[0];
	// RULE16: second instant only in double rate
	assign evt_b = !free_run_sel_sel && dsr_sel && slot_hit[1] && !conflict;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sub_reg   <= 5'h00;
			cnt_reg   <= 10'h000;
			armed_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			if (free_run_sel_sel)
			begin
				armed_reg <= 1'b0;
			end
			else if (sync_rise)
			begin
				sub_reg   <= 5'h00;
				cnt_reg   <= 10'h000;
				armed_reg <= 1'b1;
			end
			else if (armed_reg)
			begin
				if (sub_reg == 5'(sched_pkg::SLOT_TICK_CYC - 1))
				begin
					sub_reg <= 5'h00;
					if (cnt_reg == 10'h3FF)
						armed_reg <= 1'b0;
					cnt_reg <= cnt_reg + 10'h001;
				end
				else
				begin
					sub_reg <= sub_reg + 5'h01;
				end
			end
		end
	end

	// free-run period counter, only meaningful in free_run_sel operation
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			free_cnt_reg <= 24'h000000;
		else if (clk_en)
		begin
			if (!free_run_sel_sel || free_cnt_reg == 24'(FREE_RUN_CYC - 1))
				free_cnt_reg <= 24'h000000;
			else
				free_cnt_reg <= free_cnt_reg + 24'h000001;
		end
	end

	// ==================================================
	// sample latch
	// RULE12: simultaneous mode holds the sample taken at the sync edge
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			hold_reg <= 10'h000;
		else if (clk_en && sync_rise && simul_sel)
			hold_reg <= sample_in;
	end

	// ==================================================
	// init phase three sequencer
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_reg      <= sched_pkg::ST_IDLE;
			rerun_reg      <= 3'h0;
			st_done_reg    <= 1'b0;
			st_pass_reg    <= 1'b0;
			final_cnt_reg  <= 2'h0;
			selftest_start <= 1'b0;
		end
		else if (clk_en)
		begin
			selftest_start <= 1'b0;
			case (state_reg)
				sched_pkg::ST_IDLE:
				begin
					if (go_wr)
					begin
						state_reg      <= sched_pkg::ST_SELFTEST;
						rerun_reg      <= 3'h0;
						st_done_reg    <= 1'b0;
						st_pass_reg    <= 1'b0;
						final_cnt_reg  <= 2'h0;
						selftest_start <= 1'b1;
					end
				end
				sched_pkg::ST_SELFTEST:
				begin
					if (!st_done_reg && selftest_done)
					begin
						// RULE3: one pass ends repetition
						if (selftest_pass)
						begin
							st_done_reg <= 1'b1;
							st_pass_reg <= 1'b1;
						end
						// RULE2: rerun while under the repeat limit
						else if (rerun_reg < cfg_reg.rpt)
						begin
							rerun_reg      <= rerun_reg + 3'h1;
							// RULE19: restart raw offset, deflection, offset
							selftest_start <= 1'b1;
						end
						else
						begin
							st_done_reg <= 1'b1;
						end
					end
					// RULE4: first event after completion sends the first final
					if (st_done_reg && evt_a)
					begin
						state_reg     <= sched_pkg::ST_FINAL;
						final_cnt_reg <= 2'h1;
					end
				end
				sched_pkg::ST_FINAL:
				begin
					// RULE5: second final, the next event leaves
					if (evt_a)
					begin
						final_cnt_reg <= 2'(sched_pkg::FINAL_MSG_CNT);
						if (final_cnt_reg == 2'(sched_pkg::FINAL_MSG_CNT))
							state_reg <= st_pass_reg ? sched_pkg::ST_NORMAL
								: sched_pkg::ST_HALT;
					end
				end
				// RULE20: normal transmission after a pass
				sched_pkg::ST_NORMAL: state_reg <= sched_pkg::ST_NORMAL;
				default: state_reg <= sched_pkg::ST_HALT;
			endcase
		end
	end

	// RULE6: busy messages counted for software, saturating
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			busy_cnt_reg <= '0;
		else if (clk_en)
		begin
			if (go_wr && state_reg == sched_pkg::ST_IDLE)
				busy_cnt_reg <= '0;
			else if (evt_a && state_reg == sched_pkg::ST_SELFTEST
				&& !st_done_reg && busy_cnt_reg != '1)
				busy_cnt_reg <= busy_cnt_reg + 1'b1;
		end
	end

	// ==================================================
	// frame launch
	// RULE5: finals still owed in this phase
	assign fin_open = state_reg == sched_pkg::ST_FINAL
		&& final_cnt_reg != 2'(sched_pkg::FINAL_MSG_CNT);
	// slot A decides what the period carries; a failed phase leaves silently
	assign send_a = evt_a && (state_reg == sched_pkg::ST_SELFTEST
		|| state_reg == sched_pkg::ST_NORMAL
		|| (state_reg == sched_pkg::ST_FINAL && (fin_open || st_pass_reg)));
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tx_start <= 1'b0;
			tx_frame <= '0;
		end
		else if (clk_en)
		begin
			tx_start <= 1'b0;
			if (send_a)
			begin
				tx_start        <= 1'b1;
				tx_frame.slot_b <= 1'b0;
				// RULE1: status codes replace data during the phase
				if (state_reg == sched_pkg::ST_SELFTEST && !st_done_reg)
				begin
					// RULE22: busy until the test completes
					tx_frame.kind <= sched_pkg::KIND_BUSY;
					tx_frame.data <= BUSY_CODE;
				end
				else if (state_reg == sched_pkg::ST_SELFTEST || fin_open)
				begin
					tx_frame.kind <= st_pass_reg ? sched_pkg::KIND_READY
						: sched_pkg::KIND_DEFECT;
					tx_frame.data <= st_pass_reg ? READY_CODE : DEFECT_CODE;
				end
				else
				begin
					tx_frame.kind <= sched_pkg::KIND_DATA;
					// RULE14: latched at the send instant itself
					tx_frame.data <= simul_sel ? hold_reg : sample_in;
				end
			end
			else if (evt_b && state_reg == sched_pkg::ST_NORMAL)
			begin
				tx_start        <= 1'b1;
				tx_frame.slot_b <= 1'b1;
				tx_frame.kind   <= sched_pkg::KIND_DATA;
				tx_frame.data   <= sample_in;
			end
			// RULE17: slot B repeats the status frame of slot A
			else if (evt_b && state_reg != sched_pkg::ST_IDLE
				&& state_reg != sched_pkg::ST_HALT
				&& tx_frame.kind != sched_pkg::KIND_DATA)
			begin
				tx_start        <= 1'b1;
				tx_frame.slot_b <= 1'b1;
			end
		end
	end

	// ==================================================
	// programming entry
	// RULE10: sync commands still watched in phase one, even free_run_sel
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			prog_mode <= 1'b0;
		else if (clk_en && init1_active && prog_entry_cmd && !cfg_reg.lock)
			prog_mode <= 1'b1;
	end

	// ==================================================
	// apb slave, one wait state; write lands at the pready edge
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pready     <= 1'b0;
			pslverr    <= 1'b0;
			prdata     <= 32'h0000_0000;
			cfg_reg    <= sched_pkg::cfg_t'(18'(sched_pkg::CFG_RESET));
			slot_a_reg <= 10'h000;
			slot_b_reg <= 10'h000;
		end
		else if (clk_en)
		begin
			pready <= psel && penable && !pready;
			if (psel && penable && !pready)
			begin
				pslverr <= 1'b0;
				prdata  <= 32'h0000_0000;
				if (paddr == sched_pkg::ADDR_CFG)
					prdata <= 32'(cfg_reg);
				else if (paddr == sched_pkg::ADDR_SLOT)
					prdata <= {6'h00, slot_b_reg, 6'h00, slot_a_reg};
				else if (paddr == sched_pkg::ADDR_CTRL)
					prdata <= 32'h0000_0000;
				else if (paddr == sched_pkg::ADDR_STATUS)
					prdata <= {24'h000000, prog_mode, st_pass_reg, st_done_reg,
						rerun_reg, state_reg[1:0]};
				else if (paddr == sched_pkg::ADDR_COUNT)
					prdata <= {20'h00000, busy_cnt_reg};
				else
					pslverr <= 1'b1;
			end
			if (psel && penable && pready && pwrite)
			begin
				if (paddr == sched_pkg::ADDR_CFG)
					cfg_reg <= sched_pkg::cfg_t'(pwdata[17:0]);
				else if (paddr == sched_pkg::ADDR_SLOT)
				begin
					slot_a_reg <= pwdata[sched_pkg::SLOT_A_LSB +: 10];
					slot_b_reg <= pwdata[sched_pkg::SLOT_B_LSB +: 10];
				end
			end
		end
	end

	// ==================================================
	// checks
	sequence sync_at_zero;
		sync_rise && clk_en && !free_run_sel_sel && state_reg == sched_pkg::ST_NORMAL
			&& slot_a_reg == 10'h000 ##1 clk_en;
	endsequence

	sequence test_failed;
		clk_en && state_reg == sched_pkg::ST_SELFTEST && !st_done_reg
			&& selftest_done && !selftest_pass;
	endsequence

	chk_rerun_on_fail: assert property (@(posedge clk) disable iff (!arst_n) // RULE2
		test_failed and rerun_reg < cfg_reg.rpt |=> selftest_start && !st_done_reg)
		else $error("failed test not rerun");
	chk_stop_on_pass: assert property (@(posedge clk) disable iff (!arst_n) // RULE3
		clk_en && state_reg == sched_pkg::ST_SELFTEST && !st_done_reg && selftest_done
		&& selftest_pass |=> !selftest_start && st_pass_reg && st_done_reg)
		else $error("test repeated after pass");
	chk_rerun_limit: assert property (@(posedge clk) disable iff (!arst_n) // RULE2
		test_failed and rerun_reg >= cfg_reg.rpt |=> !selftest_start && st_done_reg)
		else $error("rerun beyond limit");
	chk_busy_frame: assert property (@(posedge clk) disable iff (!arst_n) // RULE22
		clk_en && evt_a && state_reg == sched_pkg::ST_SELFTEST && !st_done_reg
		|=> tx_start && tx_frame.kind == sched_pkg::KIND_BUSY)
		else $error("busy message missing");
	chk_two_finals: assert property (@(posedge clk) disable iff (!arst_n) // RULE5
		clk_en && evt_a && state_reg == sched_pkg::ST_FINAL && !fin_open
		|=> state_reg != sched_pkg::ST_FINAL
		&& !(tx_start && tx_frame.kind != sched_pkg::KIND_DATA))
		else $error("final message count wrong");
	chk_final_code: assert property (@(posedge clk) disable iff (!arst_n) // RULE5
		clk_en && evt_a && fin_open |=> tx_start && tx_frame.kind
		== (st_pass_reg ? sched_pkg::KIND_READY : sched_pkg::KIND_DEFECT))
		else $error("final message missing");
	chk_free_run_sel_no_sync: assert property (@(posedge clk) disable iff (!arst_n) // RULE9
		clk_en && free_run_sel_sel |=> !armed_reg)
		else $error("sync answered in free_run_sel mode");
	chk_slot_a_start: assert property (@(posedge clk) disable iff (!arst_n) // RULE21
		sync_at_zero |=> tx_start && !tx_frame.slot_b)
		else $error("slot A frame not launched");
	chk_simul_latch: assert property (@(posedge clk) disable iff (!arst_n) // RULE12
		clk_en && sync_rise && simul_sel |=> hold_reg == $past(sample_in))
		else $error("sync edge sample not held");
	chk_b_suppress: assert property (@(posedge clk) disable iff (!arst_n) // RULE18
		clk_en && conflict && !evt_a |=> !(tx_start && tx_frame.slot_b))
		else $error("conflicting slot B sent");
	chk_prog_lock: assert property (@(posedge clk) disable iff (!arst_n) // RULE10
		clk_en && cfg_reg.lock && !prog_mode |=> !prog_mode)
		else $error("programming entered while locked");

endmodule : sensor_slot_sched

// ==== shared/sched_pkg.sv ====
package sched_pkg;

	// ==================================================
	// timing
	localparam int unsigned CLK_NS        = 20;
	localparam int unsigned SLOT_RES_NS   = 500;
	localparam int unsigned SLOT_TICK_CYC = (SLOT_RES_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned FREE_RUN_US   = 228;
	localparam int unsigned FREE_RUN_CYC  = FREE_RUN_US * 1000 / CLK_NS;
	localparam int unsigned FINAL_MSG_CNT = 2;
	localparam int unsigned SLOT_W        = 10;

	// nominal phase-three figures, the busy counter must hold the largest
	localparam int unsigned BUSY_MAX_ASYNC10 = 2107;
	localparam real         T3_ASYNC10_MS    = 480.85;
	localparam int unsigned BUSY_MAX_SYNC8   = 906;
	localparam real         T3_SYNC8_MS      = 454.00;
	localparam int unsigned BUSY_CNT_W       = 12;

	// ==================================================
	// register map
	localparam logic [7:0] ADDR_CFG    = 8'h00;
	localparam logic [7:0] ADDR_SLOT   = 8'h04;
	localparam logic [7:0] ADDR_CTRL   = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0C;
	localparam logic [7:0] ADDR_COUNT  = 8'h10;

	localparam int unsigned CFG_MODE_LSB  = 0;
	localparam int unsigned CFG_LAT_BIT   = 2;
	localparam int unsigned CFG_FREE_BIT  = 3;
	localparam int unsigned CFG_RPT_LSB   = 4;
	localparam int unsigned CFG_LOCK_BIT  = 7;
	localparam int unsigned CFG_FLEN_LSB  = 8;
	localparam int unsigned SLOT_A_LSB    = 0;
	localparam int unsigned SLOT_B_LSB    = 16;
	localparam int unsigned CTRL_GO_BIT   = 0;
	localparam logic [31:0] CFG_RESET     = 32'h0000_1400;

	// ==================================================
	// encodings
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_DSR    = 2'h1;
	localparam logic       LAT_SIMUL   = 1'b0;

	typedef enum logic [2:0] {
		ST_IDLE     = 3'b000,
		ST_SELFTEST = 3'b001,
		ST_FINAL    = 3'b010,
		ST_NORMAL   = 3'b011,
		ST_HALT     = 3'b100
	} seq_state_t;

	typedef enum logic [1:0] {
		KIND_DATA   = 2'b00,
		KIND_BUSY   = 2'b01,
		KIND_READY  = 2'b10,
		KIND_DEFECT = 2'b11
	} msg_kind_t;

	// msb first, so the fields land on their register bit positions
	typedef struct packed {
		logic [SLOT_W-1:0] flen;
		logic              lock;
		logic [2:0]        rpt;
		logic              free_run;
		logic              latency;
		logic [1:0]        mode;
	} cfg_t;

	typedef struct packed {
		msg_kind_t         kind;
		logic              slot_b;
		logic [SLOT_W-1:0] data;
	} tx_frame_t;

endpackage : sched_pkg

// ==== verif/bus_master_model.sv ====
`timescale 1ns/100ps
// ==========
// far side: sync source, self-test engine and frame log
module bus_master_model #(
	parameter int PERIOD = 800,
	parameter int ST_CYC = 1500
) (
	input  wire logic                 clk,
	input  wire logic                 arst_n,
	input  wire logic [2:0]           fails,
	input  wire logic                 selftest_start,
	input  wire logic                 tx_start,
	input  wire sched_pkg::tx_frame_t tx_frame,
	output logic                      sync_rise,
	output logic [9:0]                sample_in,
	output logic                      selftest_done,
	output logic                      selftest_pass
);
	sched_pkg::tx_frame_t fq[$];
	int                   dq[$];
	int                   gq[$];
	logic [9:0]           sq[$];
	logic [9:0]           nq[$];
	logic [9:0]           at_sync;
	int                   ph;
	int                   since_sync;
	int                   since_tx;
	int                   st_left;
	int                   starts;

	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			fq.delete();
			dq.delete();
			gq.delete();
			sq.delete();
			nq.delete();
			ph <= 0;
			sync_rise <= 1'b0;
			sample_in <= 10'h000;
			at_sync <= 10'h000;
			since_sync <= 0;
			since_tx <= 0;
			st_left <= 0;
			starts <= 0;
			selftest_done <= 1'b0;
			selftest_pass <= 1'b0;
		end
		else
		begin
			ph <= (ph == PERIOD - 1) ? 0 : ph + 1;
			sync_rise <= (ph == 0);
			// sample moves well clear of slot instants, so each frame has one right value
			if (ph == 50 || ph == 500)
				sample_in <= sample_in + 10'h00B;
			since_sync <= sync_rise ? 0 : since_sync + 1;
			since_tx <= tx_start ? 0 : since_tx + 1;
			if (sync_rise)
				at_sync <= sample_in;
			if (tx_start)
			begin
				fq.push_back(tx_frame);
				dq.push_back(since_sync + 1);
				gq.push_back(since_tx + 1);
				sq.push_back(at_sync);
				nq.push_back(sample_in);
			end
			// attempt number above the fail count passes
			selftest_done <= (st_left == 1);
			selftest_pass <= (st_left == 1) && (starts > fails);
			if (selftest_start)
			begin
				starts <= starts + 1;
				st_left <= ST_CYC;
			end
			else if (st_left > 0)
				st_left <= st_left - 1;
		end
	end
endmodule : bus_master_model

// ==== verif/sensor_bus_init3_and_slot_scheduler_test.sv ====
`timescale 1ns/100ps
module sensor_bus_init3_and_slot_scheduler_test;
	localparam int FR = 50;
	logic                 clk, arst_n, clk_en, psel, penable, pwrite, pready, pslverr;
	logic                 sync_rise, selftest_done, selftest_pass, selftest_start;
	logic                 init1_active, prog_entry_cmd, tx_start, prog_mode, rerr;
	logic [7:0]           paddr;
	logic [31:0]          pwdata, prdata, rdat;
	logic [9:0]           sample_in;
	logic [2:0]           fails;
	sched_pkg::tx_frame_t tx_frame;
	int                   err_count, check_count, cyc;

	sensor_slot_sched #(.FREE_RUN_CYC(FR)) dut (
		.clk, .arst_n, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .sync_rise, .sample_in, .selftest_done,
		.selftest_pass, .init1_active, .prog_entry_cmd, .selftest_start,
		.tx_start, .tx_frame, .prog_mode
	);
	bus_master_model far (
		.clk, .arst_n, .fails, .selftest_start, .tx_start, .tx_frame,
		.sync_rise, .sample_in, .selftest_done, .selftest_pass
	);

	// ==========
	// clock and hang guard
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 60000)
		begin
			err_count++;
			test_done();
		end
	end

	// ==========
	// helpers
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	function automatic logic [31:0] mk(input logic [1:0] md, input logic lat, input logic fr,
		input logic [2:0] rp);
		logic [31:0] v;
		v = sched_pkg::CFG_RESET;
		v[sched_pkg::CFG_MODE_LSB +: 2] = md;
		v[sched_pkg::CFG_LAT_BIT] = lat;
		v[sched_pkg::CFG_FREE_BIT] = fr;
		v[sched_pkg::CFG_RPT_LSB +: 3] = rp;
		return v;
	endfunction : mk

	// ==========
	// one phase-three run, then the frame log is walked
	task automatic run(input string nm, input logic [31:0] cfg, input logic [9:0] sa,
		input logic [9:0] sb, input logic [2:0] nf, input int n);
		sched_pkg::tx_frame_t f;
		logic                 asy, dsr, ps;
		logic [1:0]           fin;
		int                   per, nb, rp, len;
		arst_n <= 1'b0;
		fails <= nf;
		@(posedge clk);
		arst_n <= 1'b1;
		apb(1'b1, sched_pkg::ADDR_CFG, cfg);
		apb(1'b1, sched_pkg::ADDR_SLOT, {6'h00, sb, 6'h00, sa});
		apb(1'b1, sched_pkg::ADDR_CTRL, 32'h0000_0001);
		repeat (n) @(posedge clk);
		rp = cfg[6:4];
		ps = nf <= rp;
		fin = ps ? sched_pkg::KIND_READY : sched_pkg::KIND_DEFECT;
		asy = cfg[1:0] == sched_pkg::MODE_NORMAL && cfg[3] && sa == 10'h000;
		dsr = cfg[1:0] == sched_pkg::MODE_DSR;
		per = (dsr && !(sa < sb + cfg[17:8] && sb < sa + cfg[17:8])) ? 2 : 1;
		check("starts", far.starts, (ps ? nf : rp) + 1);
		nb = 0;
		while (nb < far.fq.size() && far.fq[nb].kind == sched_pkg::KIND_BUSY)
			nb++;
		len = nb + 2 * per;
		check("busy seen", 32'(nb > 0), 1);
		check("count", 32'(ps ? far.fq.size() > len : far.fq.size() == len), 1);
		for (int i = 0; i < far.fq.size(); i++)
		begin
			f = far.fq[i];
			check("kind", f.kind, i < nb ? 2'h1 : (i < len ? fin : 2'h0));
			check("slot_b", f.slot_b, per == 2 ? i % 2 : 0);
			if (asy && i > 0)
				check("gap", far.gq[i], FR);
			else if (!asy)
				check("offset", far.dq[i], 2 + 25 * (f.slot_b ? sb : sa));
			if (!asy && f.kind == sched_pkg::KIND_DATA)
				check("data", f.data, dsr || cfg[2] ? far.nq[i] : far.sq[i]);
			if (per == 2 && i % 2 == 1 && f.kind != sched_pkg::KIND_DATA)
				check("dup", {f.kind, f.data}, {far.fq[i - 1].kind, far.fq[i - 1].data});
		end
		apb(1'b0, sched_pkg::ADDR_STATUS, 32'h0);
		check("pass bit", rdat[6], ps);
		check("reruns", rdat[4:2], ps ? nf : rp);
		apb(1'b0, sched_pkg::ADDR_COUNT, 32'h0);
		if (per == 1)
			check("busy count", rdat, nb);
		$display("test %s done", nm);
	endtask : run

	// ==========
	// main sequence
	initial
	begin
		{clk_en, arst_n, psel, penable, pwrite, init1_active, prog_entry_cmd} = 7'h40;
		paddr = 8'h00;
		pwdata = 32'h0;
		fails = 3'h0;
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		apb(1'b0, sched_pkg::ADDR_CFG, 32'h0);
		check("cfg reset", rdat, sched_pkg::CFG_RESET);
		apb(1'b0, 8'h14, 32'h0);
		check("unmapped err", rerr, 1);
		check("unmapped data", rdat, 0);
		// entry needs phase one and a clear lock; the last pass sets the sticky flag
		for (int k = 0; k < 3; k++)
		begin
			apb(1'b1, sched_pkg::ADDR_CFG, mk(2'h0, 1'b0, 1'b1, 3'h0) | 32'(k == 1) << 7);
			init1_active <= k > 0;
			@(posedge clk);
			prog_entry_cmd <= 1'b1;
			@(posedge clk);
			prog_entry_cmd <= 1'b0;
			repeat (4) @(posedge clk);
			check("prog", prog_mode, k == 2);
		end
		init1_active <= 1'b0;
		$display("test regs done");
		run("simul", mk(sched_pkg::MODE_NORMAL, 1'b0, 1'b0, 3'h2), 10'd4, 10'd28, 3'h1, 8000);
		run("synlat", mk(sched_pkg::MODE_NORMAL, 1'b1, 1'b0, 3'h0), 10'd0, 10'd28, 3'h0, 6000);
		run("dsr", mk(sched_pkg::MODE_DSR, 1'b0, 1'b0, 3'h1), 10'd4, 10'd28, 3'h1, 8000);
		run("dsr_ovl", mk(sched_pkg::MODE_DSR, 1'b1, 1'b0, 3'h1), 10'd4, 10'd12, 3'h2, 6000);
		run("free_run_sel", mk(sched_pkg::MODE_NORMAL, 1'b0, 1'b1, 3'h0), 10'd0, 10'd28, 3'h0, 4000);
		run("free_a4", mk(sched_pkg::MODE_NORMAL, 1'b0, 1'b1, 3'h0), 10'd4, 10'd28, 3'h0, 5000);
		test_done();
	end
endmodule : sensor_bus_init3_and_slot_scheduler_test
